// ==== common/pll_ctrl_pkg.sv ====
/*
 * Constants for the loop control bank: register indices, field positions,
 * reset values, bus response codes.
 * Assumes a 32-bit AXI4-Lite register port; printed offsets are indices.
 */
package pll_ctrl_pkg;

	// printed offsets are not all multiples of four: byte address = 4 * index
	localparam logic [11:0] IDX_PD_LO    = 12'h790;
	localparam logic [11:0] IDX_PD_HI    = 12'h791;
	localparam logic [11:0] IDX_CAL_DIV  = 12'h792;
	localparam logic [11:0] IDX_PREDIV   = 12'h793;
	localparam logic [11:0] IDX_CP       = 12'h794;
	localparam logic [11:0] IDX_CP_TRIM  = 12'h795;
	localparam logic [11:0] IDX_TUNE_A   = 12'h796;
	localparam logic [11:0] IDX_TUNE_B   = 12'h797;
	localparam int          ADDR_LSB     = 2;
	localparam int          ADDR_W       = 14;

	// reset values; bit 1 of the low power-down register starts at one
	localparam logic [7:0] RST_PD_LO   = 8'h02;
	localparam logic [7:0] RST_PD_HI   = 8'h00;
	localparam logic [7:0] RST_CAL_DIV = 8'h02;
	localparam logic [7:0] RST_PREDIV  = 8'h00;
	localparam logic [7:0] RST_CP      = 8'h04;
	localparam logic [7:0] RST_CP_TRIM = 8'h08;
	localparam logic [7:0] RST_TUNE_A  = 8'hD2;
	// low six bits of the second tuning register start at 0x20
	localparam logic [7:0] RST_TUNE_B  = 8'h20;

	// writable bit masks; zero bits are read-only reserved
	localparam logic [7:0] MSK_PD_LO   = 8'hFF;
	localparam logic [7:0] MSK_PD_HI   = 8'hFF;
	localparam logic [7:0] MSK_CAL_DIV = 8'h03;
	localparam logic [7:0] MSK_PREDIV  = 8'h03;
	localparam logic [7:0] MSK_CP      = 8'hFF;
	localparam logic [7:0] MSK_CP_TRIM = 8'hFF;
	localparam logic [7:0] MSK_TUNE_A  = 8'hFF;
	localparam logic [7:0] MSK_TUNE_B  = 8'hFF;

	// field positions
	localparam int BIT_CAL_RESET  = 1;
	localparam int BIT_OSC_HOLD   = 0;
	localparam int PD_HI_BITS     = 5;
	localparam int CP_W           = 6;
	localparam int PREDIV_W       = 2;
	localparam int TRIM_W         = 4;
	localparam int TUNE_LSB       = 4;

	// charge pump current step in microamps
	localparam int CP_STEP_UA     = 100;
	localparam int CP_BASE_UA     = 100;
	localparam int CP_UA_W        = 13;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== sim/pll_ctrl_asserts.sv ====
/* Port checker for pll_ctrl.
   Bound into every pll_ctrl instance; one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_asserts (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// read data channel
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// loop controls
	input wire logic [7:0]  loop_section_off_lo,
	input wire logic        cal_reset,
	input wire logic        osc_divider_hold,
	input wire logic        obs_clk_driver_en,
	input wire logic [2:0]  ref_divide_ratio,
	input wire logic [12:0] pump_current_ua,
	input wire logic [5:0]  pump_current_code
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////
property p_rst_dflt;
	$rose(aresetn) |-> loop_section_off_lo == 8'h02 && cal_reset
		&& !osc_divider_hold && pump_current_code == 6'h04;
endproperty
a_rst_dflt: assert property (p_rst_dflt)
	else $error("control reset values wrong");
property p_hold_idle;
	$rose(aresetn) |-> !osc_divider_hold [*3];
endproperty
a_hold_idle: assert property (p_hold_idle)
	else $error("divider hold set without a write");
property p_obs_gate;
	obs_clk_driver_en == !osc_divider_hold;
endproperty
a_obs_gate: assert property (p_obs_gate)
	else $error("observation driver not gated by hold");
property p_ratio;
	ref_divide_ratio >= 3'h1 && ref_divide_ratio <= 3'h4;
endproperty
a_ratio: assert property (p_ratio)
	else $error("divide ratio out of range");
property p_ua;
	pump_current_ua == 13'h064 + 13'(pump_current_code) * 13'h064;
endproperty
a_ua: assert property (p_ua)
	else $error("pump current does not match code");
property p_upper_zero;
	s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
endproperty
a_upper_zero: assert property (p_upper_zero)
	else $error("upper read data not zero");
property p_rd_hold;
	s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_rd_hold: assert property (p_rd_hold)
	else $error("read data dropped before taken");
endmodule

bind pll_ctrl pll_ctrl_asserts pll_ctrl_asserts_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.loop_section_off_lo(loop_section_off_lo), .cal_reset(cal_reset),
	.osc_divider_hold(osc_divider_hold),
	.obs_clk_driver_en(obs_clk_driver_en),
	.ref_divide_ratio(ref_divide_ratio), .pump_current_ua(pump_current_ua),
	.pump_current_code(pump_current_code));
`default_nettype wire

// ==== sim/pll_ctrl_tb_top.sv ====
/* Self-checking bench for pll_ctrl over AXI4-Lite.
   Needs pll_ctrl_pkg, the design and its bound checker. */
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_tb_top;
import pll_ctrl_pkg::*;
logic        aclk = 1'b0, aresetn = 1'b0;
logic [13:0] awaddr = '0, araddr = '0;
logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic        arvalid = 1'b0, rready = 1'b0;
logic [31:0] wdata = '0, rdata;
logic [3:0]  wstrb = '0, trim, tune;
logic        awready, wready, bvalid, arready, rvalid, cal, hold, obs;
logic [1:0]  bresp, rresp;
logic [7:0]  off_lo, tune_b;
logic [4:0]  off_hi;
logic [2:0]  ratio;
logic [12:0] ua;
logic [5:0]  code;
int          miscompares = 0, num_checks = 0, cycles = 0, seed = 68;
logic [7:0]  mdl [8];
localparam logic [7:0] RSTV [8] = '{RST_PD_LO, RST_PD_HI, RST_CAL_DIV,
	RST_PREDIV, RST_CP, RST_CP_TRIM, RST_TUNE_A, RST_TUNE_B};
localparam logic [7:0] MSKV [8] = '{MSK_PD_LO, MSK_PD_HI, MSK_CAL_DIV,
	MSK_PREDIV, MSK_CP, MSK_CP_TRIM, MSK_TUNE_A, MSK_TUNE_B};
// corner writes: predivider codes, pump extremes, hold, power-down
localparam logic [19:0] CORNER [11] = '{{IDX_PREDIV, 8'hFC},
	{IDX_PREDIV, 8'hFD}, {IDX_PREDIV, 8'hFE}, {IDX_PREDIV, 8'hFF},
	{IDX_CP, 8'hC0}, {IDX_CP, 8'h3F}, {IDX_CAL_DIV, 8'hFD},
	{IDX_CAL_DIV, 8'hFE}, {IDX_PD_LO, 8'hFF}, {IDX_PD_HI, 8'hFF},
	{IDX_PD_LO, 8'h00}};

pll_ctrl pll_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
	.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
	.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
	.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
	.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
	.s_axi_rvalid(rvalid), .s_axi_rready(rready),
	.loop_section_off_lo(off_lo), .loop_section_off_hi(off_hi),
	.cal_reset(cal), .osc_divider_hold(hold), .obs_clk_driver_en(obs),
	.ref_divide_ratio(ratio), .pump_current_ua(ua),
	.pump_current_code(code), .pump_trim_field(trim),
	.loop_tuning_field(tune), .loop_tuning_b(tune_b));

always #5 aclk = ~aclk;
////////////////////////////////////////
task automatic give_verdict();
	if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask

always @(posedge aclk) begin
	cycles <= cycles + 1;
	if (cycles == 6000) begin
		miscompares = miscompares + 1;
		give_verdict();
	end
end

task automatic chk(input string nm, input logic [63:0] exp, got);
	num_checks++;
	if (got !== exp) begin
		miscompares++;
		$display("FAIL %s expected %h seen %h", nm, exp, got);
	end
endtask

function automatic logic [1:0] exp_resp(input logic [11:0] idx);
	return (idx[11:3] == 9'h0F2) ? RESP_OKAY : RESP_SLVERR;
endfunction

task automatic do_reset();
	aresetn <= 1'b0;
	repeat (16) @(posedge aclk);
	aresetn <= 1'b1;
	for (int i = 0; i < 8; i++) mdl[i] = RSTV[i];
endtask

task automatic wr(input logic [11:0] idx, input logic [7:0] d,
	input logic [3:0] s);
	logic aw_ok, w_ok;
	@(posedge aclk);
	awaddr <= {idx, 2'b00};
	wdata <= ({$random(seed)} & 32'hFFFFFF00) | {24'h0, d};
	wstrb <= s;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	aw_ok = 1'b0;
	w_ok = 1'b0;
	while (!(aw_ok && w_ok)) begin
		@(posedge aclk);
		if (awready === 1'b1) begin
			aw_ok = 1'b1;
			awvalid <= 1'b0;
		end
		if (wready === 1'b1) begin
			w_ok = 1'b1;
			wvalid <= 1'b0;
		end
	end
	while (bvalid !== 1'b1) @(posedge aclk);
	bready <= 1'b0;
	chk("bresp", exp_resp(idx), bresp);
	// unmapped or strobe-less writes leave the bank alone
	if (exp_resp(idx) == RESP_OKAY && s[0])
		mdl[idx[2:0]] = (mdl[idx[2:0]] & ~MSKV[idx[2:0]])
			| (d & MSKV[idx[2:0]]);
endtask

task automatic rd(input logic [11:0] idx);
	logic late;
	late = 1'($random(seed));
	@(posedge aclk);
	araddr <= {idx, 2'b00};
	arvalid <= 1'b1;
	rready <= !late;
	do @(posedge aclk); while (arready !== 1'b1);
	arvalid <= 1'b0;
	while (rvalid !== 1'b1) @(posedge aclk);
	if (late) begin
		// late rready: read data must stand until taken
		rready <= 1'b1;
		@(posedge aclk);
	end
	rready <= 1'b0;
	chk("rdata", (exp_resp(idx) == RESP_OKAY) ? mdl[idx[2:0]] : 0, rdata);
	chk("rresp", exp_resp(idx), rresp);
endtask

task automatic chk_ctl();
	repeat (3) @(posedge aclk);
	chk("ratio", mdl[3][1:0] + 3'h1, ratio);
	chk("ua", 13'h064 + mdl[4][5:0] * 13'h064, ua);
	chk("hold", {mdl[2][0], ~mdl[2][0], mdl[2][1]}, {hold, obs, cal});
	chk("ctl", {mdl[0], mdl[1][4:0], mdl[4][5:0], mdl[5][3:0], mdl[6][7:4],
		mdl[7]}, {off_lo, off_hi, code, trim, tune, tune_b});
endtask
////////////////////////////////////////
initial begin
	logic [11:0] idx;
	logic [7:0]  d;
	logic [3:0]  s;
	do_reset();
	chk_ctl();
	for (int i = 0; i < 9; i++) rd(12'h790 + 12'(i));
	for (int n = 0; n < 51; n++) begin
		idx = 12'h790 + 12'({$random(seed)} % 9);
		d = 8'($random(seed));
		s = 4'($random(seed));
		if (n < 11) begin
			idx = CORNER[n][19:8];
			d = CORNER[n][7:0];
			s = 4'hF;
		end
		wr(idx, d, s);
		chk_ctl();
		rd(idx);
	end
	do_reset();
	chk_ctl();
	rd(IDX_PD_LO);
	give_verdict();
end
endmodule
`default_nettype wire

// ==== verilog/pll_ctrl.sv ====
/*
 * Loop power-down and divider control bank behind an AXI4-Lite slave.
 * Assumes a 100 MHz aclk, synchronous active-low reset, and an analog loop
 * that consumes the decoded control outputs.
 */
// Decided for this implementation: register access over AXI4-Lite.
// How it works
// - power-down bit1 resets to one; software clears
// - divider hold bit holds oscillator divider reset
// - divider hold also gates observation clock driver
// - predivider code plus one is divide ratio
// - pump current is 100 uA plus code steps
`timescale 1ns/1ps
`default_nettype none

module pll_ctrl (
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite write address
	input  wire logic [pll_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// axi4-lite read address
	input  wire logic [pll_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0]                   s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// loop controls
	output var  logic [7:0]                    loop_section_off_lo,
	output var  logic [pll_ctrl_pkg::PD_HI_BITS-1:0] loop_section_off_hi,
	output var  logic                          cal_reset,
	output var  logic                          osc_divider_hold,
	output var  logic                          obs_clk_driver_en,
	output var  logic [2:0]                    ref_divide_ratio,
	output var  logic [pll_ctrl_pkg::CP_UA_W-1:0] pump_current_ua,
	output var  logic [pll_ctrl_pkg::CP_W-1:0] pump_current_code,
	output var  logic [pll_ctrl_pkg::TRIM_W-1:0] pump_trim_field,
	output var  logic [3:0]                    loop_tuning_field,
	output var  logic [7:0]                    loop_tuning_b
);
	import pll_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////

	typedef enum {W_IDLE, W_RESP} wr_state_t;
	typedef enum {R_IDLE, R_WAIT, R_RESP} rd_state_t;

	typedef struct packed {
		wr_state_t                  wst;
		rd_state_t                  rst;
		logic                       aw_held;
		logic                       w_held;
		logic [ADDR_W-1:0]          awaddr;
		logic [7:0]                 wbyte;
		logic                       wlane;
		logic [ADDR_W-1:0]          araddr;
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic                       rhit;
		logic [31:0]                rdata;
		logic [7:0]                 off_lo;
		logic [PD_HI_BITS-1:0]      off_hi;
		logic                       cal_rst;
		logic                       hold;
		logic                       obs_en;
		logic [2:0]                 ratio;
		logic [CP_UA_W-1:0]         cp_ua;
		logic [CP_W-1:0]            cp_code;
		logic [TRIM_W-1:0]          trim;
		logic [3:0]                 tune_a;
		logic [7:0]                 tune_b;
	} ctrl_t;

	ctrl_t st;
	ctrl_t next_st;

	// byte address to register slot; unmapped gives hit = 0
	function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
		logic [11:0] idx;
		idx = a[ADDR_W-1:ADDR_LSB];
		if (idx >= IDX_PD_LO && idx <= IDX_TUNE_B)
			decode = {1'b1, 3'(idx - IDX_PD_LO)};
		else
			decode = 4'h0;
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic        wr_en;
	logic [2:0]  wr_sel;
	logic [7:0]  bank_rd;
	logic [63:0] regs;
	logic [3:0]  wdec;
	logic [3:0]  rdec;

	assign wdec   = decode(st.awaddr);
	assign rdec   = decode(st.araddr);
	assign wr_en  = (st.wst == W_IDLE) && st.aw_held && st.w_held
		&& wdec[3] && st.wlane;
	assign wr_sel = wdec[2:0];

	reg_bank u_bank (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.wr_en    (wr_en),
		.wr_sel   (wr_sel),
		.wr_data  (st.wbyte),
		.rd_sel   (rdec[2:0]),
		.rd_data  (bank_rd),
		.contents (regs)
	);

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_st = st;
		next_st.awready = 1'b0;
		next_st.wready  = 1'b0;
		next_st.arready = 1'b0;

		// write: take address and data in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wbyte  = s_axi_wdata[7:0];
			next_st.wlane  = s_axi_wstrb[0];
		end
		case (st.wst)
			W_IDLE: begin
				if (st.aw_held && st.w_held) begin
					next_st.aw_held = 1'b0;
					next_st.w_held  = 1'b0;
					next_st.bvalid  = 1'b1;
					next_st.bresp   = wdec[3] ? RESP_OKAY : RESP_SLVERR;
					next_st.wst     = W_RESP;
				end else begin
					next_st.awready = !st.aw_held && !st.awready
						&& s_axi_awvalid;
					next_st.wready  = !st.w_held && !st.wready
						&& s_axi_wvalid;
					if (s_axi_awvalid && st.awready)
						next_st.awready = 1'b0;
					if (s_axi_wvalid && st.wready)
						next_st.wready = 1'b0;
				end
			end
			W_RESP: begin
				if (s_axi_bready) begin
					next_st.bvalid = 1'b0;
					next_st.wst    = W_IDLE;
				end
			end
			default: next_st.wst = W_IDLE;
		endcase

		// read: address, one cycle in the bank, then data
		case (st.rst)
			R_IDLE: begin
				if (s_axi_arvalid && st.arready) begin
					next_st.araddr = s_axi_araddr;
					next_st.rst    = R_WAIT;
				end else begin
					next_st.arready = s_axi_arvalid;
				end
			end
			R_WAIT: begin
				next_st.rhit = rdec[3];
				next_st.rst  = R_RESP;
			end
			R_RESP: begin
				if (!st.rvalid) begin
					// reserved and upper bits read as zero
					next_st.rdata  = st.rhit ? {24'h0, bank_rd} : 32'h0;
					next_st.rresp  = st.rhit ? RESP_OKAY : RESP_SLVERR;
					next_st.rvalid = 1'b1;
				end else if (s_axi_rready) begin
					next_st.rvalid = 1'b0;
					next_st.rst    = R_IDLE;
				end
			end
			default: next_st.rst = R_IDLE;
		endcase

		// decoded controls; software owns the power-down policy
		next_st.off_lo  = regs[8*0 +: 8];
		next_st.off_hi  = regs[8*1 +: PD_HI_BITS];
		next_st.cal_rst = regs[8*2 + BIT_CAL_RESET];
		next_st.hold    = regs[8*2 + BIT_OSC_HOLD];
		next_st.obs_en  = !regs[8*2 + BIT_OSC_HOLD];
		next_st.ratio   = {1'b0, regs[8*3 +: PREDIV_W]} + 3'h1;
		next_st.cp_code = regs[8*4 +: CP_W];
		next_st.cp_ua   = CP_UA_W'(CP_BASE_UA)
			+ CP_UA_W'(regs[8*4 +: CP_W]) * CP_UA_W'(CP_STEP_UA);
		next_st.trim    = regs[8*5 +: TRIM_W];
		next_st.tune_a  = regs[8*6 + TUNE_LSB +: 4];
		next_st.tune_b  = regs[8*7 +: 8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st         <= '0;
			st.wst     <= W_IDLE;
			st.rst     <= R_IDLE;
			st.off_lo  <= RST_PD_LO;
			st.off_hi  <= RST_PD_HI[PD_HI_BITS-1:0];
			st.cal_rst <= RST_CAL_DIV[BIT_CAL_RESET];
			st.hold    <= RST_CAL_DIV[BIT_OSC_HOLD];
			st.obs_en  <= !RST_CAL_DIV[BIT_OSC_HOLD];
			st.ratio   <= 3'h1;
			st.cp_code <= RST_CP[CP_W-1:0];
			st.cp_ua   <= CP_UA_W'(CP_BASE_UA)
				+ CP_UA_W'(RST_CP[CP_W-1:0]) * CP_UA_W'(CP_STEP_UA);
			st.trim    <= RST_CP_TRIM[TRIM_W-1:0];
			st.tune_a  <= RST_TUNE_A[TUNE_LSB +: 4];
			st.tune_b  <= RST_TUNE_B;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign s_axi_awready       = st.awready;
	assign s_axi_wready        = st.wready;
	assign s_axi_bvalid        = st.bvalid;
	assign s_axi_bresp         = st.bresp;
	assign s_axi_arready       = st.arready;
	assign s_axi_rvalid        = st.rvalid;
	assign s_axi_rresp         = st.rresp;
	assign s_axi_rdata         = st.rdata;
	assign loop_section_off_lo = st.off_lo;
	assign loop_section_off_hi = st.off_hi;
	assign cal_reset           = st.cal_rst;
	assign osc_divider_hold    = st.hold;
	assign obs_clk_driver_en   = st.obs_en;
	assign ref_divide_ratio    = st.ratio;
	assign pump_current_ua     = st.cp_ua;
	assign pump_current_code   = st.cp_code;
	assign pump_trim_field     = st.trim;
	assign loop_tuning_field   = st.tune_a;
	assign loop_tuning_b       = st.tune_b;

endmodule

`default_nettype wire

// ==== verilog/reg_bank.sv ====
/*
 * Eight-entry byte register store with registered read data.
 * Assumes one write and one read port, used by the loop control top.
 */
`timescale 1ns/1ps
`default_nettype none

module reg_bank (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// write port
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_sel,
	input  wire logic [7:0] wr_data,
	// read port
	input  wire logic [2:0] rd_sel,
	output var  logic [7:0] rd_data,
	// all contents, for the control outputs
	output var  logic [63:0] contents
);
	import pll_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0][7:0] mem;
		logic [7:0]      rd;
	} bank_t;

	bank_t st;
	bank_t next_st;

	localparam logic [63:0] RST_ALL = {RST_TUNE_B, RST_TUNE_A, RST_CP_TRIM,
		RST_CP, RST_PREDIV, RST_CAL_DIV, RST_PD_HI, RST_PD_LO};
	localparam logic [63:0] MSK_ALL = {MSK_TUNE_B, MSK_TUNE_A, MSK_CP_TRIM,
		MSK_CP, MSK_PREDIV, MSK_CAL_DIV, MSK_PD_HI, MSK_PD_LO};

	always_comb begin
		next_st = st;
		if (wr_en) begin
			// reserved read-only bits keep their reset value
			next_st.mem[wr_sel] = (wr_data & MSK_ALL[wr_sel*8 +: 8])
				| (st.mem[wr_sel] & ~MSK_ALL[wr_sel*8 +: 8]);
		end
		next_st.rd = st.mem[rd_sel];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.mem <= RST_ALL;
			st.rd  <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data  = st.rd;
	assign contents = st.mem;

endmodule

`default_nettype wire
